// *** inc/peak_det_regs.svh ***
// Register indices, field positions, reset values and counts of the block peak power detector.
`ifndef PEAK_DET_REGS_SVH
`define PEAK_DET_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PD_IDX_ENABLE 6'h00
`define PD_IDX_LEN_LOW 6'h01
`define PD_IDX_LEN_MID 6'h02
`define PD_IDX_LEN_TOP 6'h03
`define PD_IDX_THR_UU 6'h07
`define PD_IDX_THR_UL 6'h08
`define PD_IDX_THR_LU 6'h09
`define PD_IDX_THR_LL 6'h0a
`define PD_IDX_DWELL_LOW 6'h0b
`define PD_IDX_DWELL_HIGH 6'h0c
`define PD_IDX_STATUS 6'h10
`define PD_IDX_MASK 6'h11
`define PD_IDX_FLAGS 6'h12
`define PD_IDX_PEAK_LOW 6'h13
`define PD_IDX_PEAK_HIGH 6'h14

// ----------------------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------------------
`define PD_ENABLE_BIT 0
`define PD_LEN_TOP_BIT 0
`define PD_EVT_HIGH_BIT 0
`define PD_EVT_LOW_BIT 1
`define PD_EVT_BLOCK_BIT 2
`define PD_EVT_W 3
`define PD_RST_BYTE 8'h00
`define PD_RST_EVT 3'h0
`define PD_RAW_LAST 3'h7
`define PD_THR_SHIFT 9

`endif

// *** inc/peak_det_pkg.sv ***
// Types shared by the block peak power detector.
package peak_det_pkg;

  // Software configuration of the detector.
  typedef struct packed {
    logic enable;
    logic [16:0] blockLen;
    logic [7:0] thrUpperUpper;
    logic [7:0] thrUpperLower;
    logic [7:0] thrLowerUpper;
    logic [7:0] thrLowerLower;
    logic [15:0] dwell;
  } cfg_t;

  // Hysteresis output flags.
  typedef struct packed {
    logic high;
    logic low;
  } flags_t;

  // Register bus answer state.
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage

// *** design/block_peak_power_detector.sv ***
// Block peak power detector with hysteresis flags and an Avalon-MM register slave.
`timescale 1ns/10ps
`include "peak_det_regs.svh"
// Operation
// R1 - The detector runs only while its enable bit is one.
// R2 - Block peak is taken over a programmable length counted in reduced samples.
// R3 - Each reduced sample is the peak of eight consecutive raw samples.
// R4 - Block length is a 17-bit count from two bytes and one top bit.
// R5 - Software keeps length a multiple of five times factor for divide 4 or 6.
// R6 - Software keeps length a multiple of ten times factor for divide 8 to 32.
// R7 - Four independent 8-bit thresholds drive a hysteresis comparison of block peak.
// R8 - Thresholds scale from 0 to 256, where 256 is full peak amplitude.
// R9 - Flags set above upper threshold, clear after dwell below lower threshold.
// R10 - Dwell is a 16-bit count of eighth sample clock cycles.
// R11 - While disabled, flags stay low and block accumulation restarts on enable.
module block_peak_power_detector #(
  parameter int SAMPLE_W = 14
) (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Avalon-MM register slave.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Raw converter samples, two's complement.
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] sampleData,
  // Gain control flags and interrupt.
  output logic peakFlagHigh,
  output logic peakFlagLow,
  output logic irq
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Magnitude of a signed sample; the most negative code maps to full scale.
  function automatic logic [SAMPLE_W-1:0] absMag(input logic [SAMPLE_W-1:0] s);
    absMag = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
  endfunction

  function automatic logic [SAMPLE_W-1:0] maxMag(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
    maxMag = (a > b) ? a : b;
  endfunction

  // Threshold 256 would equal full scale, so a code lands at bit SAMPLE_W-9 upward.
  function automatic logic [SAMPLE_W-1:0] scaleThr(input logic [7:0] t);
    scaleThr = SAMPLE_W'({t, {(SAMPLE_W - `PD_THR_SHIFT){1'b0}}});
  endfunction

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  peak_det_pkg::cfg_t cfg;
  peak_det_pkg::bus_state_t busState;
  logic [`PD_EVT_W-1:0] status;
  logic [`PD_EVT_W-1:0] mask;
  logic [`PD_EVT_W-1:0] events;
  logic [5:0] regIdx;
  logic accept;
  logic wrAccept;
  logic rdAccept;
  logic [31:0] next_readdata;

  assign regIdx = address[7:2];
  assign accept = clkEn && (busState == peak_det_pkg::BUS_ANSWER);
  assign wrAccept = accept && write && byteenable[0];
  assign rdAccept = accept && read;

  // Every request waits one cycle while clkEn is high; holding it here keeps decode off the critical path.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      busState <= peak_det_pkg::BUS_IDLE;
    else if (clkEn)
    begin
      case (busState)
        peak_det_pkg::BUS_IDLE: if (read || write) busState <= peak_det_pkg::BUS_ANSWER;
        peak_det_pkg::BUS_ANSWER: busState <= peak_det_pkg::BUS_IDLE;
        default: busState <= peak_det_pkg::BUS_IDLE;
      endcase
    end
  end

  assign waitrequest = (read || write) && !accept;

  // Configuration writes; the length is assembled from its three parts.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg <= '0;
      mask <= `PD_RST_EVT;
    end
    else if (wrAccept)
    begin
      case (regIdx)
        `PD_IDX_ENABLE: cfg.enable <= writedata[`PD_ENABLE_BIT]; // R1
        `PD_IDX_LEN_LOW: cfg.blockLen[7:0] <= writedata[7:0]; // R4
        `PD_IDX_LEN_MID: cfg.blockLen[15:8] <= writedata[7:0]; // R4
        `PD_IDX_LEN_TOP: cfg.blockLen[16] <= writedata[`PD_LEN_TOP_BIT]; // R4
        `PD_IDX_THR_UU: cfg.thrUpperUpper <= writedata[7:0]; // R7
        `PD_IDX_THR_UL: cfg.thrUpperLower <= writedata[7:0]; // R7
        `PD_IDX_THR_LU: cfg.thrLowerUpper <= writedata[7:0]; // R7
        `PD_IDX_THR_LL: cfg.thrLowerLower <= writedata[7:0]; // R7
        `PD_IDX_DWELL_LOW: cfg.dwell[7:0] <= writedata[7:0]; // R10
        `PD_IDX_DWELL_HIGH: cfg.dwell[15:8] <= writedata[7:0]; // R10
        `PD_IDX_MASK: mask <= writedata[`PD_EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Raw to reduced samples
  // --------------------------------------------------------------------------
  logic [2:0] rawCount;
  logic [SAMPLE_W-1:0] rawPeak;
  logic [SAMPLE_W-1:0] redPeak;
  logic redValid;
  logic [SAMPLE_W-1:0] sampleMag;

  assign sampleMag = absMag(sampleData);

  // Eight raw magnitudes fold into one reduced peak; disabling restarts the group.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rawCount <= '0;
      rawPeak <= '0;
      redPeak <= '0;
      redValid <= 1'b0;
    end
    else if (clkEn)
    begin
      redValid <= 1'b0;
      if (!cfg.enable)
      begin
        rawCount <= '0; // R11
        rawPeak <= '0;
      end
      else if (sampleValid)
      begin
        if (rawCount == `PD_RAW_LAST) // R3
        begin
          redPeak <= maxMag(rawPeak, sampleMag);
          redValid <= 1'b1;
          rawCount <= '0;
          rawPeak <= '0;
        end
        else
        begin
          rawPeak <= maxMag(rawPeak, sampleMag);
          rawCount <= rawCount + 3'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Block peak
  // --------------------------------------------------------------------------
  logic [16:0] blkCount;
  logic [SAMPLE_W-1:0] blkAcc;
  logic [SAMPLE_W-1:0] blockPeak;
  logic blockDone;
  logic blockLast;

  // A length of zero behaves as one, so a block always ends.
  assign blockLast = ({1'b0, blkCount} + 18'h1) >= {1'b0, cfg.blockLen};

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blkCount <= '0;
      blkAcc <= '0;
      blockPeak <= '0;
      blockDone <= 1'b0;
    end
    else if (clkEn)
    begin
      blockDone <= 1'b0;
      if (!cfg.enable)
      begin
        blkCount <= '0; // R11
        blkAcc <= '0;
      end
      else if (redValid)
      begin
        if (blockLast) // R2
        begin
          blockPeak <= maxMag(blkAcc, redPeak);
          blockDone <= 1'b1;
          blkCount <= '0;
          blkAcc <= '0;
        end
        else
        begin
          blkAcc <= maxMag(blkAcc, redPeak);
          blkCount <= blkCount + 17'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Hysteresis comparison and dwell
  // --------------------------------------------------------------------------
  logic aboveUU;
  logic aboveLU;
  logic belowUL;
  logic belowLL;
  logic holdHigh;
  logic holdLow;
  logic [15:0] dwellHigh;
  logic [15:0] dwellLow;
  logic setHigh;
  logic setLow;
  logic clrHigh;
  logic clrLow;

  assign aboveUU = blockPeak > scaleThr(cfg.thrUpperUpper); // R8
  assign aboveLU = blockPeak > scaleThr(cfg.thrLowerUpper); // R8
  assign belowUL = blockPeak < scaleThr(cfg.thrUpperLower); // R8
  assign belowLL = blockPeak < scaleThr(cfg.thrLowerLower); // R8
  assign setHigh = blockDone && aboveUU; // R9
  assign setLow = blockDone && aboveLU; // R9
  assign clrHigh = holdHigh && (dwellHigh >= cfg.dwell); // R9
  assign clrLow = holdLow && (dwellLow >= cfg.dwell); // R9

  // The hold marks remember that the last block stayed below its lower threshold.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      holdHigh <= 1'b0;
      holdLow <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!cfg.enable)
      begin
        holdHigh <= 1'b0;
        holdLow <= 1'b0;
      end
      else if (blockDone)
      begin
        holdHigh <= belowUL;
        holdLow <= belowLL;
      end
    end
  end

  // Dwell advances once per reduced sample, i.e. per eighth of the sample clock.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dwellHigh <= '0;
      dwellLow <= '0;
    end
    else if (clkEn)
    begin
      if (!cfg.enable || (blockDone && !belowUL))
        dwellHigh <= '0;
      else if (redValid && holdHigh && dwellHigh != 16'hffff)
        dwellHigh <= dwellHigh + 16'h1; // R10
      if (!cfg.enable || (blockDone && !belowLL))
        dwellLow <= '0;
      else if (redValid && holdLow && dwellLow != 16'hffff)
        dwellLow <= dwellLow + 16'h1; // R10
    end
  end

  // A fresh crossing beats a dwell expiry in the same cycle.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      peakFlagHigh <= 1'b0;
      peakFlagLow <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!cfg.enable)
      begin
        peakFlagHigh <= 1'b0; // R11
        peakFlagLow <= 1'b0; // R11
      end
      else
      begin
        if (setHigh)
          peakFlagHigh <= 1'b1; // R9
        else if (clrHigh)
          peakFlagHigh <= 1'b0; // R9
        if (setLow)
          peakFlagLow <= 1'b1; // R9
        else if (clrLow)
          peakFlagLow <= 1'b0; // R9
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and read data
  // --------------------------------------------------------------------------
  assign events[`PD_EVT_HIGH_BIT] = clkEn && cfg.enable && setHigh && !peakFlagHigh;
  assign events[`PD_EVT_LOW_BIT] = clkEn && cfg.enable && setLow && !peakFlagLow;
  assign events[`PD_EVT_BLOCK_BIT] = clkEn && blockDone;

  // Reading clears only the bits that the read returned; read data are captured a cycle before the clear,
  // so an event that lands between capture and clear must survive, and one in the clear cycle wins too.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      status <= `PD_RST_EVT;
    else if (rdAccept && regIdx == `PD_IDX_STATUS)
      status <= (status & ~readdata[`PD_EVT_W-1:0]) | events;
    else
      status <= status | events;
  end

  assign irq = |(status & mask);

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (regIdx)
      `PD_IDX_ENABLE: next_readdata[`PD_ENABLE_BIT] = cfg.enable;
      `PD_IDX_LEN_LOW: next_readdata[7:0] = cfg.blockLen[7:0];
      `PD_IDX_LEN_MID: next_readdata[7:0] = cfg.blockLen[15:8];
      `PD_IDX_LEN_TOP: next_readdata[`PD_LEN_TOP_BIT] = cfg.blockLen[16];
      `PD_IDX_THR_UU: next_readdata[7:0] = cfg.thrUpperUpper;
      `PD_IDX_THR_UL: next_readdata[7:0] = cfg.thrUpperLower;
      `PD_IDX_THR_LU: next_readdata[7:0] = cfg.thrLowerUpper;
      `PD_IDX_THR_LL: next_readdata[7:0] = cfg.thrLowerLower;
      `PD_IDX_DWELL_LOW: next_readdata[7:0] = cfg.dwell[7:0];
      `PD_IDX_DWELL_HIGH: next_readdata[7:0] = cfg.dwell[15:8];
      `PD_IDX_STATUS: next_readdata[`PD_EVT_W-1:0] = status;
      `PD_IDX_MASK: next_readdata[`PD_EVT_W-1:0] = mask;
      `PD_IDX_FLAGS: next_readdata[1:0] = {peakFlagLow, peakFlagHigh};
      `PD_IDX_PEAK_LOW: next_readdata[7:0] = 8'(blockPeak);
      `PD_IDX_PEAK_HIGH: next_readdata[7:0] = 8'(blockPeak >> 8);
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured on the idle-to-answer edge, so it stands at the accepting edge.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      readdata <= 32'h0000_0000;
    else if (clkEn && busState == peak_det_pkg::BUS_IDLE && read)
      readdata <= next_readdata;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  disabled_flags_low_a: assert property ((clkEn && !cfg.enable) |=> !peakFlagHigh && !peakFlagLow) // R11
    else $error("Flags set while detector disabled.");
  disabled_no_reduce_a: assert property ((clkEn && !cfg.enable) |=> !redValid) // R1
    else $error("Reduced sample produced while disabled.");
  reduce_eight_a: assert property ((redValid && $past(clkEn))
    |-> $past(rawCount) == `PD_RAW_LAST && $past(sampleValid)) // R3
    else $error("Reduced sample not formed from eight raw samples.");
  block_length_a: assert property ((clkEn && redValid && cfg.enable && !blockLast) |=> !blockDone) // R2
    else $error("Block ended before its programmed length.");
  length_write_a: assert property ((wrAccept && regIdx == `PD_IDX_LEN_TOP)
    |=> cfg.blockLen[16] == $past(writedata[`PD_LEN_TOP_BIT])) // R4
    else $error("Block length top bit not stored.");
  high_set_a: assert property ((clkEn && cfg.enable && blockDone && aboveUU) |=> peakFlagHigh) // R9
    else $error("High flag not set above upper threshold.");
  low_hold_a: assert property ((peakFlagLow && clkEn && cfg.enable && !holdLow) |=> peakFlagLow) // R9
    else $error("Low flag cleared without dwell below threshold.");
  dwell_hold_a: assert property ((peakFlagHigh && clkEn && cfg.enable && !setHigh && dwellHigh < cfg.dwell)
    |=> peakFlagHigh) // R10
    else $error("High flag cleared before dwell expired.");
  threshold_scale_a: assert property ((clkEn && cfg.enable && blockDone && !peakFlagHigh
    && blockPeak <= scaleThr(cfg.thrUpperUpper)) |=> !peakFlagHigh) // R8
    else $error("High flag set by a peak not above the threshold.");
  bus_answer_a: assert property ((clkEn && (read || write) && waitrequest) ##1 clkEn |-> !waitrequest)
    else $error("Bus request not answered in one cycle.");

  block_done_c: cover property (blockDone ##[1:20] blockDone);
  flag_set_c: cover property ($rose(peakFlagHigh));
  flag_clear_c: cover property ($fell(peakFlagLow) && cfg.enable);
  irq_c: cover property ($rose(irq));

endmodule

// *** verification/adc_sample_model.sv ***
// Behavioural model of the converter sample stream that feeds the detector.
`timescale 1ns/10ps
module adc_sample_model #(
  parameter int SAMPLE_W = 14
) (
  // Clock.
  input wire logic mclk,
  // Raw sample stream.
  output logic sampleValid,
  output logic [SAMPLE_W-1:0] sampleData
);
  // The stream starts idle.
  initial
  begin
    sampleValid = 1'b0;
    sampleData = '0;
  end

  // Idle cycle; the data lines toggle so that no one can rely on a stale sample.
  task automatic idle();
    sampleValid <= 1'b0;
    sampleData <= ~sampleData;
    @(posedge mclk);
  endtask

  // One sample after some idle cycles, so the stream can run back to back or slowly.
  task automatic send(input logic [SAMPLE_W-1:0] v, input int gap);
    repeat (gap) idle();
    sampleValid <= 1'b1;
    sampleData <= v;
    @(posedge mclk);
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the block peak power detector.
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------
  // Signals and instances
  // ------------------------------------------
  localparam int SW = 14;
  logic mclk, rst_b, clkEn, read, write, waitrequest, irq, peakFlagHigh, peakFlagLow, sampleValid;
  logic [7:0] address, v;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [SW-1:0] sampleData;
  logic [15:0] pk;
  int err_total, comparisons;
  logic [5:0] idx[12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h05, 6'h0b, 6'h0c, 6'h11};
  int lens[3] = '{20, 30, 80};

  block_peak_power_detector #(.SAMPLE_W(SW)) uut (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sampleValid(sampleValid), .sampleData(sampleData), .peakFlagHigh(peakFlagHigh),
    .peakFlagLow(peakFlagLow), .irq(irq));
  adc_sample_model #(.SAMPLE_W(SW)) src (.mclk(mclk), .sampleValid(sampleValid), .sampleData(sampleData));

  // Free-running 125 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One transfer, held until waitrequest is seen low; an edge passes before the next one.
  task automatic bus(input logic isWr, input logic [5:0] i, input logic [7:0] d, input logic [3:0] be);
    int n;
    read <= ~isWr;
    write <= isWr;
    address <= {i, 2'b00};
    writedata <= {24'h000000, d};
    byteenable <= be;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      err_total++;
      end_sim();
    end
    @(posedge mclk);
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'h1);
  endtask

  task automatic rdchk(input logic [5:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00, 4'h0);
    chk_reg(rd, {24'h000000, e});
  endtask

  // Random samples no larger than lim in magnitude; pk follows the largest.
  task automatic feed(input int n, input int lim);
    logic [SW-1:0] s;
    for (int k = 0; k < n; k++)
    begin
      s = SW'($urandom_range(lim, 0));
      if ({2'b00, s} > pk) pk = {2'b00, s};
      if ($urandom_range(1, 0) == 1) s = ~s + 1'b1;
      src.send(s, $urandom_range(2, 0));
    end
    src.idle();
  endtask

  // One group of eight whose peak is v, then time for the flags to settle.
  task automatic put(input logic [SW-1:0] v);
    src.send(v, 0);
    repeat (7) src.send('0, 1);
    repeat (4) src.idle();
  endtask

  // Restarts the detector with a new length and thresholds, then clears status.
  task automatic cfg(input int len, input logic [7:0] uu, input logic [7:0] ul, input logic [7:0] lu,
    input logic [7:0] ll);
    wr(6'h00, 8'h00);
    wr(6'h01, len[7:0]);
    wr(6'h02, len[15:8]);
    wr(6'h03, {7'h00, len[16]});
    wr(6'h07, uu);
    wr(6'h08, ul);
    wr(6'h09, lu);
    wr(6'h0a, ll);
    wr(6'h00, 8'h01);
    bus(1'b0, 6'h10, 8'h00, 4'h0);
  endtask

  // Main sequence: reset, register map, block lengths, hysteresis, enable.
  initial
  begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    err_total = 0;
    comparisons = 0;
    pk = '0;
    void'($urandom(44));
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    // Reset values, single-bit registers and the unmapped place.
    foreach (idx[i])
    begin
      rdchk(idx[i], 8'h00);
      v = 8'($urandom);
      wr(idx[i], v);
      rdchk(idx[i], idx[i] == 6'h05 ? 8'h00 : (idx[i] == 6'h00 || idx[i] == 6'h03) ? {7'h00, v[0]} :
        idx[i] == 6'h11 ? {5'h00, v[2:0]} : v);
    end
    // A write with its byte lane off is answered but leaves the register alone.
    wr(6'h07, 8'h3c);
    bus(1'b1, 6'h07, 8'hc3, 4'h0);
    rdchk(6'h07, 8'h3c);
    wr(6'h0b, 8'h04);
    wr(6'h0c, 8'h00);
    // Block done comes only after the full count of reduced samples.
    foreach (lens[j])
    begin
      cfg(lens[j], 8'hff, 8'hff, 8'hff, 8'hff);
      pk = '0;
      feed(lens[j] * 8 - 8, 8000);
      repeat (4) src.idle();
      rdchk(6'h10, 8'h00);
      feed(8, 8000);
      repeat (4) src.idle();
      rdchk(6'h10, 8'h04);
      rdchk(6'h13, pk[7:0]);
      rdchk(6'h14, pk[15:8]);
    end
    // The comparison is strict; the most negative code exceeds the top threshold.
    cfg(1, 8'hff, 8'h80, 8'h40, 8'h20);
    put(14'h1fe0);
    chk_pin(peakFlagHigh, 1'b0);
    chk_pin(peakFlagLow, 1'b1);
    rdchk(6'h12, 8'h02);
    rdchk(6'h10, 8'h06);
    chk_pin(irq, 1'b0);
    wr(6'h11, 8'h01);
    put(14'h2000);
    chk_pin(peakFlagHigh, 1'b1);
    rdchk(6'h12, 8'h03);
    chk_pin(irq, 1'b1);
    rdchk(6'h10, 8'h05);
    chk_pin(irq, 1'b0);
    // A block equal to the lower threshold is not below it; then the dwell must pass.
    put(14'h1000);
    put('0);
    chk_pin(peakFlagHigh, 1'b1);
    repeat (8) put('0);
    chk_pin(peakFlagHigh, 1'b0);
    chk_pin(peakFlagLow, 1'b0);
    // Disabling drops the flags, ignores samples and forgets a partial group.
    put(14'h2000);
    chk_pin(peakFlagHigh, 1'b1);
    wr(6'h00, 8'h00);
    repeat (2) src.idle();
    chk_pin(peakFlagHigh, 1'b0);
    chk_pin(peakFlagLow, 1'b0);
    bus(1'b0, 6'h10, 8'h00, 4'h0);
    put(14'h1f40);
    rdchk(6'h10, 8'h00);
    wr(6'h00, 8'h01);
    repeat (5) src.send(14'h1f40, 0);
    src.idle();
    wr(6'h00, 8'h00);
    wr(6'h00, 8'h01);
    put(14'h0064);
    rdchk(6'h13, 8'h64);
    rdchk(6'h14, 8'h00);
    // A low clock enable freezes the detector, so full-scale samples seen then never reach a group.
    clkEn <= 1'b0;
    repeat (3) src.send(14'h2000, 0);
    clkEn <= 1'b1;
    put(14'h0032);
    rdchk(6'h13, 8'h32);
    rdchk(6'h14, 8'h00);
    end_sim();
  end
endmodule
